// *** bench/pcm_board.sv ***
// Board model that drives the device pins
`timescale 1ns/10ps
module pcm_board (
    // Clock and control
    input wire logic i_clk_sys,
    input wire logic i_run,
    input wire logic i_pwrdn,
    // Pin levels and drive flags
    output logic [2:0] o_gclk,
    output logic o_clr,
    output logic [31:0] o_pin,
    output logic [31:0] o_drv
);
    logic [31:0] r;
    logic [31:0] s;
    integer seed = 16076;
    // Quiet pins at start, no clock or clear edge before i_run
    initial begin
        o_gclk = 3'h0;
        o_clr = 1'b0;
        o_pin = 32'h0;
        o_drv = 32'h0000_0118;
    end
    // Random levels; pin 1, when released, shows the inverse of its last level
    always @(negedge i_clk_sys) begin
        r = $random(seed);
        s = $random(seed);
        o_gclk <= i_run ? s[6:4] : 3'h0;
        o_clr <= i_run & (&s[3:0]);
        o_drv <= 32'h0000_0118 | (32'h2 & r);
        o_pin <= {r[31:9], i_pwrdn, r[7:2], (r[1] ? r[12] : ~o_pin[1]), r[0]};
    end
endmodule // pcm_board

// *** bench/pcm_macrocell_ctrl_bench.sv ***
// Self-checking bench for the macrocell fabric
`timescale 1ns/10ps
`include "pcm_defines.svh"
module pcm_macrocell_ctrl_bench;
    import pcm_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic run = 1'b0;
    logic pwrdn_req = 1'b0;
    logic [2:0] gclk;
    logic clr;
    logic [31:0] pin;
    logic [31:0] drv;
    pcm_mc_cfg_t [31:0] cfg;
    pcm_blk_cfg_t [1:0] blk;
    logic [15:0] sig = 16'h5a3c;
    wire [31:0] io_out;
    wire [31:0] oe_n;
    wire [31:0] fast;
    wire pwr_dn;
    wire stby;
    wire [15:0] usig;
    integer bad_count = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer live = 0;
    int ph = 0;
    // Model state: bus copies, keeper, flip-flop, outputs
    logic b1, b3, b4, b5, bg, bgp, bc, kp, q, o0, o2, oen;
    always #2 i_clk_sys = ~i_clk_sys;
    pcm_board i_pcm_board (.i_clk_sys(i_clk_sys), .i_run(run), .i_pwrdn(pwrdn_req),
        .o_gclk(gclk), .o_clr(clr), .o_pin(pin), .o_drv(drv));
    pcm_macrocell_ctrl i_pcm_macrocell_ctrl (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_global_clock_pins(gclk), .i_global_clear(clr), .i_oe_pins(pin[6:5]),
        .i_ded_ext_drive(6'h3f), .i_io_pin(pin), .i_io_ext_drive(drv),
        .o_io_out(io_out), .o_io_oe_n(oe_n), .o_io_fast(fast), .i_cfg_mc(cfg),
        .i_cfg_blk(blk), .i_cfg_keeper(1'b1), .i_cfg_pwrdn_en(1'b1),
        .i_cfg_standby_en(1'b1), .i_cfg_signature(sig), .o_power_down(pwr_dn),
        .o_standby(stby), .o_user_signature(usig));
    // ****************************************
    // Reference model
    // ****************************************
    always @(posedge i_clk_sys) begin
        live = i_rst ? 0 : live + 1;
        if (i_rst) begin
            {b1, b3, b4, b5, bg, bgp, bc, kp, q} = 9'h0;
            oen = 1'b1;
            o0 = cfg[0].out_pol;
            o2 = cfg[2].out_pol;
        end else if (!pin[8]) begin
            o0 = b1 ^ cfg[0].out_pol;
            o2 = q ^ cfg[2].out_pol;
            oen = !b5;
            if (bc && cfg[2].async_reset_select != PCM_CLR_OFF) q = 1'b0;
            else if (b3 & b4) q = 1'b1;
            else if (bg & !bgp & (b3 | !cfg[2].clk_en_on)) q = b1;
            bgp = bg;
            bg = gclk[ph];
            b5 = pin[5];
            bc = clr;
            b3 = pin[3];
            b4 = pin[4];
            b1 = drv[1] ? pin[1] : kp;
            kp = b1;
        end
    end
    // Compare one value and count it
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task close_out();
        if (bad_count == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Checks on settled outputs
    always @(negedge i_clk_sys) begin
        if (live > 2) begin
            chk("out0", o0, io_out[0]);
            chk("out2", o2, io_out[2]);
            chk("oe_n", 32'hffff_fbfa | {21'h0, oen, 10'h0}, oe_n);
            chk("fast", 32'h4, fast);
            chk("sig", sig, usig);
            chk("pwrdn", pin[8], pwr_dn);
            if (pin[8]) chk("stby", 1, stby);
        end
    end
    // Hang guard
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            close_out();
        end
    end
    // ****************************************
    // Main sequence: one pass per clock pin
    // ****************************************
    initial begin
        cfg = '0;
        blk = '0;
        blk[0].sel[0] = 7'h07;
        blk[0].sel[1] = 7'h09;
        blk[0].sel[2] = 7'h0a;
        cfg[0].output_enable_mux = PCM_OE_OUTPUT;
        cfg[0].sum_pt_en = 5'h08;
        cfg[0].pt_true[3] = 40'h1;
        cfg[0].out_pol = 1'b1;
        cfg[2] = cfg[0];
        cfg[2].out_reg = 1'b1;
        cfg[2].slew_fast = 1'b1;
        cfg[2].pt_true[0] = 40'h2;
        cfg[2].pt_true[2] = 40'h6;
        cfg[2].async_preset_select = 1'b1;
        cfg[10].output_enable_mux = PCM_OE_PIN0;
        for (ph = 0; ph < 3; ph++) begin
            cfg[2].clk_src = pcm_clk_src_t'(ph[1:0]);
            cfg[2].clk_en_on = (ph != 1);
            cfg[2].out_pol = ph[0];
            cfg[2].async_reset_select = (ph == 1) ? PCM_CLR_OFF : PCM_CLR_GLOBAL;
            i_rst = 1'b1;
            run = 1'b0;
            repeat (8) @(negedge i_clk_sys);
            i_rst = 1'b0;
            repeat (2) @(negedge i_clk_sys);
            run = 1'b1;
            repeat (150) @(negedge i_clk_sys);
            pwrdn_req = 1'b1;
            repeat (40) @(negedge i_clk_sys);
            pwrdn_req = 1'b0;
            repeat (150) @(negedge i_clk_sys);
        end
        close_out();
    end
endmodule // pcm_macrocell_ctrl_bench

// *** src/pcm_defines.svh ***
// Constants for the macrocell fabric: sizes, bus layout, term roles, reset values
`ifndef PCM_DEFINES_SVH
`define PCM_DEFINES_SVH
// ****************************************
// Sizes
// ****************************************
`define PCM_NUM_MC 32
`define PCM_NUM_IO 32
`define PCM_NUM_DED 6
`define PCM_NUM_GCLK 3
`define PCM_NUM_BLK 2
`define PCM_MC_PER_BLK 16
`define PCM_BLK_IN 40
`define PCM_NUM_PT 5
`define PCM_CHAIN_LEN 8
`define PCM_REGION 4
`define PCM_BUS_W 70
`define PCM_SIG_W 16
// ****************************************
// Global bus layout (dedicated, I/O, feedback)
// ****************************************
`define PCM_BUS_DED_LSB 0
`define PCM_BUS_OE0 4
`define PCM_BUS_OE1 5
`define PCM_BUS_IO_LSB 6
`define PCM_BUS_FB_LSB 38
// ****************************************
// Product term roles and pin positions
// ****************************************
`define PCM_PT_CLK 0
`define PCM_PT_CLR 1
`define PCM_PT_PRE 2
`define PCM_POWER_DOWN_PIN_A_IDX 8
`define PCM_POWER_DOWN_PIN_B_IDX 24
// ****************************************
// Reset values
// ****************************************
`define PCM_Q_RST 1'b0
`define PCM_OE_N_RST 1'b1
`define PCM_SLEW_RST 1'b0
`endif

// *** src/pcm_macrocell.sv ***
// One macrocell: product terms, sum logic, flip-flop and output select
`timescale 1ns/10ps
`include "pcm_defines.svh"
module pcm_macrocell (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Fabric inputs
    input wire logic i_hold,
    input wire pcm_pkg::pcm_mc_cfg_t i_cfg,
    input wire logic [`PCM_BLK_IN-1:0] i_blk,
    input wire logic [`PCM_NUM_GCLK-1:0] i_gclk,
    input wire logic i_global_clear,
    input wire logic [`PCM_REGION-1:0] i_fold,
    input wire logic i_casc,
    // Results
    output logic o_fold,
    output logic o_sum,
    output logic o_out,
    output logic o_fb
);
    import pcm_pkg::*;
    logic [`PCM_NUM_PT-1:0] pt; // Product terms
    logic q; // Flip-flop state
    logic clk_prev; // Selected clock, last cycle
    logic clk_val; // Selected clock level
    logic clk_edge; // Rising edge seen this cycle
    logic ce_ok; // Clock enable passes
    logic clr_act; // Asynchronous clear active
    logic pre_act; // Asynchronous preset active
    logic sum; // Sum term
    // Product terms; an empty term is off, not a constant one
    always_comb begin
        for (int k = 0; k < `PCM_NUM_PT; k++) begin
            pt[k] = (|(i_cfg.pt_true[k] | i_cfg.pt_comp[k]))
                && (&((i_blk | ~i_cfg.pt_true[k]) & (~i_blk | ~i_cfg.pt_comp[k])));
        end
    end
    // Sum of own terms, regional foldbacks and the cascade from below
    assign sum = !i_cfg.low_power && ((|(pt & i_cfg.sum_pt_en))
        || (|(i_fold & i_cfg.fold_en)) || (i_cfg.casc_en && i_casc));
    // Clock source select
    always_comb begin
        unique case (i_cfg.clk_src)
            PCM_CLK_GLOB0: clk_val = i_gclk[0];
            PCM_CLK_GLOB1: clk_val = i_gclk[1];
            PCM_CLK_GLOB2: clk_val = i_gclk[2];
            PCM_CLK_PT: clk_val = pt[`PCM_PT_CLK];
        endcase
    end
    assign clk_edge = clk_val && !clk_prev;
    // Enable term only applies with a global clock
    assign ce_ok = !i_cfg.clk_en_on || (i_cfg.clk_src == PCM_CLK_PT) || pt[`PCM_PT_CLK];
    // Clear source select
    always_comb begin
        unique case (i_cfg.async_reset_select)
            PCM_CLR_OFF: clr_act = 1'b0;
            PCM_CLR_GLOBAL: clr_act = i_global_clear;
            PCM_CLR_TERM: clr_act = pt[`PCM_PT_CLR];
            PCM_CLR_BOTH: clr_act = i_global_clear || pt[`PCM_PT_CLR];
        endcase
    end
    assign pre_act = i_cfg.async_preset_select && pt[`PCM_PT_PRE];
    // Last clock level, frozen while held
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            clk_prev <= 1'b0;
        end else if (!i_hold) begin
            clk_prev <= clk_val;
        end
    end
    // Flip-flop: clear over preset over clocked load
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            q <= `PCM_Q_RST;
        end else if (!i_hold && !i_cfg.low_power) begin
            if (clr_act) begin
                q <= 1'b0;
            end else if (pre_act) begin
                q <= 1'b1;
            end else if (clk_edge && ce_ok) begin
                q <= sum;
            end
        end
    end
    // Foldback, output and buried feedback selects
    assign o_fold = (i_cfg.fold_src < 3'(`PCM_NUM_PT)) ? !pt[i_cfg.fold_src] : 1'b0;
    assign o_sum = sum;
    assign o_out = (i_cfg.out_reg ? q : sum) ^ i_cfg.out_pol;
    assign o_fb = i_cfg.fb_reg ? q : sum;
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_upd_cause;
        $changed(q) |-> $past(i_rst || clr_act || pre_act || clk_edge);
    endproperty
    a_upd_cause: assert property (p_upd_cause) else $error("state moved without cause");
    property p_ce_block;
        (clk_edge && i_cfg.clk_en_on && i_cfg.clk_src != PCM_CLK_PT && !pt[`PCM_PT_CLK]
            && !clr_act && !pre_act) |=> $stable(q);
    endproperty
    a_ce_block: assert property (p_ce_block) else $error("disabled edge loaded");
    property p_clr;
        clr_act && !i_hold && !i_cfg.low_power |=> !q;
    endproperty
    a_clr: assert property (p_clr) else $error("clear did not clear");
    property p_pre;
        pre_act && !clr_act && !i_hold && !i_cfg.low_power |=> q;
    endproperty
    a_pre: assert property (p_pre) else $error("preset did not set");
endmodule // pcm_macrocell

// *** src/pcm_macrocell_ctrl.sv ***
// Macrocell fabric of a 32-cell programmable device, up to its pins
`timescale 1ns/10ps
`include "pcm_defines.svh"
module pcm_macrocell_ctrl (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Dedicated input pins
    input wire logic [`PCM_NUM_GCLK-1:0] i_global_clock_pins,
    input wire logic i_global_clear,
    input wire logic [1:0] i_oe_pins,
    input wire logic [`PCM_NUM_DED-1:0] i_ded_ext_drive,
    // I/O pins
    input wire logic [`PCM_NUM_IO-1:0] i_io_pin,
    input wire logic [`PCM_NUM_IO-1:0] i_io_ext_drive,
    output logic [`PCM_NUM_IO-1:0] o_io_out,
    output logic [`PCM_NUM_IO-1:0] o_io_oe_n,
    output logic [`PCM_NUM_IO-1:0] o_io_fast,
    // Static configuration, fixed before operation
    input wire pcm_pkg::pcm_mc_cfg_t [`PCM_NUM_MC-1:0] i_cfg_mc,
    input wire pcm_pkg::pcm_blk_cfg_t [`PCM_NUM_BLK-1:0] i_cfg_blk,
    input wire logic i_cfg_keeper,
    input wire logic i_cfg_pwrdn_en,
    input wire logic i_cfg_standby_en,
    input wire logic [`PCM_SIG_W-1:0] i_cfg_signature,
    // Status
    output logic o_power_down,
    output logic o_standby,
    output logic [`PCM_SIG_W-1:0] o_user_signature
);
    import pcm_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************

    // Level seen on a pin: own drive, else board drive, else keeper or low
    function automatic logic pin_level(input logic own, input logic own_val,
        input logic ext, input logic ext_val, input logic keep, input logic kept);
        logic lvl;
        if (own) begin
            lvl = own_val;
        end else if (ext) begin
            lvl = ext_val;
        end else begin
            lvl = keep && kept;
        end
        return lvl;
    endfunction

    // Read one bus line; indices past the bus read low
    function automatic logic bus_pick(input logic [`PCM_BUS_W-1:0] bus,
        input logic [6:0] idx);
        logic val;
        if (idx < 7'(`PCM_BUS_W)) begin
            val = bus[idx];
        end else begin
            val = 1'b0;
        end
        return val;
    endfunction

    // Output enable from the selected source
    function automatic logic oe_pick(input pcm_oe_src_t src, input logic [4:0] idx,
        input logic [`PCM_BUS_W-1:0] bus);
        logic en;
        unique case (src)
            PCM_OE_INPUT: en = 1'b0;
            PCM_OE_OUTPUT: en = 1'b1;
            PCM_OE_PIN0: en = bus[`PCM_BUS_OE0];
            PCM_OE_PIN0_N: en = !bus[`PCM_BUS_OE0];
            PCM_OE_PIN1: en = bus[`PCM_BUS_OE1];
            PCM_OE_PIN1_N: en = !bus[`PCM_BUS_OE1];
            PCM_OE_IOPIN: en = bus[`PCM_BUS_IO_LSB + 32'(idx)];
            PCM_OE_MCELL: en = bus[`PCM_BUS_FB_LSB + 32'(idx)];
        endcase
        return en;
    endfunction

    // ****************************************
    // Signals
    // ****************************************

    logic [`PCM_NUM_DED-1:0] ded_drv; // Dedicated pins as driven
    logic [`PCM_NUM_DED-1:0] ded_lvl; // Dedicated pin levels
    logic [`PCM_NUM_DED-1:0] ded_kept; // Dedicated keeper state
    logic [`PCM_NUM_IO-1:0] io_lvl; // I/O pin levels
    logic [`PCM_NUM_IO-1:0] io_kept; // I/O keeper state
    logic [`PCM_NUM_IO-1:0] io_logic; // I/O levels offered to logic
    logic [`PCM_NUM_IO-1:0] pwrdn_mask; // Pins given over to power-down
    logic pwrdn_act; // Power-down in force
    logic [`PCM_BUS_W-1:0] next_bus; // Global bus, this cycle
    logic [`PCM_BUS_W-1:0] bus_q; // Global bus as latched
    logic [`PCM_NUM_BLK-1:0][`PCM_BLK_IN-1:0] blk_in; // Switch matrix outputs
    logic [`PCM_NUM_MC-1:0] mc_fold; // Foldback terms
    logic [`PCM_NUM_MC-1:0] mc_sum; // Sum terms, feed the chains
    logic [`PCM_NUM_MC-1:0] mc_out; // Output values
    logic [`PCM_NUM_MC-1:0] mc_fb; // Buried feedback
    logic [`PCM_NUM_MC-1:0] casc_in; // Cascade from the cell below
    logic [`PCM_NUM_IO-1:0] oe_want; // Enables from the selectors
    logic [`PCM_NUM_IO-1:0] slew_cfg; // Slew options gathered

    // ****************************************
    // Pins and keepers
    // ****************************************

    assign ded_drv = {i_oe_pins, i_global_clear, i_global_clock_pins};

    // Resolve each pin; a released pin keeps its level when enabled
    always_comb begin
        for (int i = 0; i < `PCM_NUM_DED; i++) begin
            ded_lvl[i] = pin_level(1'b0, 1'b0, i_ded_ext_drive[i], ded_drv[i],
                i_cfg_keeper, ded_kept[i]);
        end
        for (int i = 0; i < `PCM_NUM_IO; i++) begin
            io_lvl[i] = pin_level(!o_io_oe_n[i], o_io_out[i], i_io_ext_drive[i],
                i_io_pin[i], i_cfg_keeper, io_kept[i]);
        end
    end

    // Keeper latches follow the pins and freeze in power-down
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ded_kept <= '0;
            io_kept <= '0;
        end else if (!pwrdn_act) begin
            ded_kept <= ded_lvl;
            io_kept <= io_lvl;
        end
    end

    // ****************************************
    // Power-down
    // ****************************************

    // Pins that serve power-down when the option is on
    always_comb begin
        pwrdn_mask = '0;
        pwrdn_mask[`PCM_POWER_DOWN_PIN_A_IDX] = i_cfg_pwrdn_en;
        pwrdn_mask[`PCM_POWER_DOWN_PIN_B_IDX] = i_cfg_pwrdn_en;
    end

    // Either pin high puts the part down, read straight off the pins
    assign pwrdn_act = i_cfg_pwrdn_en && (io_lvl[`PCM_POWER_DOWN_PIN_A_IDX]
        || io_lvl[`PCM_POWER_DOWN_PIN_B_IDX]);
    assign o_power_down = pwrdn_act;

    // Power-down pins read low to the logic
    assign io_logic = io_lvl & ~pwrdn_mask;

    // ****************************************
    // Global bus and switch matrix
    // ****************************************

    // Bus holds every pin and every buried feedback
    assign next_bus = {mc_fb, io_logic, ded_lvl};

    // Latching the bus breaks feedback loops and freezes inputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bus_q <= '0;
        end else if (!pwrdn_act) begin
            bus_q <= next_bus;
        end
    end

    // Each block picks its 40 inputs from the bus
    always_comb begin
        for (int b = 0; b < `PCM_NUM_BLK; b++) begin
            for (int k = 0; k < `PCM_BLK_IN; k++) begin
                blk_in[b][k] = bus_pick(bus_q, i_cfg_blk[b].sel[k]);
            end
        end
    end

    // ****************************************
    // Macrocells
    // ****************************************

    for (genvar g = 0; g < `PCM_NUM_MC; g++) begin : g_mc
        // Chains restart every eighth cell
        if (g % `PCM_CHAIN_LEN == 0) begin : g_head
            assign casc_in[g] = 1'b0;
        end else begin : g_link
            assign casc_in[g] = mc_sum[g-1];
        end
        // Cell, fed from its block and its foldback region
        pcm_macrocell u_mc (
            .i_clk_sys(i_clk_sys),
            .i_rst(i_rst),
            .i_hold(pwrdn_act),
            .i_cfg(i_cfg_mc[g]),
            .i_blk(blk_in[g / `PCM_MC_PER_BLK]),
            .i_gclk(bus_q[`PCM_BUS_DED_LSB +: `PCM_NUM_GCLK]),
            .i_global_clear(bus_q[`PCM_BUS_DED_LSB + `PCM_NUM_GCLK]),
            .i_fold(mc_fold[(g / `PCM_REGION) * `PCM_REGION +: `PCM_REGION]),
            .i_casc(casc_in[g]),
            .o_fold(mc_fold[g]),
            .o_sum(mc_sum[g]),
            .o_out(mc_out[g]),
            .o_fb(mc_fb[g])
        );
        // Enable source and slew option of this pin
        assign oe_want[g] = oe_pick(i_cfg_mc[g].output_enable_mux, i_cfg_mc[g].oe_idx, bus_q);
        assign slew_cfg[g] = i_cfg_mc[g].slew_fast;
    end

    // ****************************************
    // Output pins
    // ****************************************

    // Output data; on reset each pin shows its buffer polarity
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            for (int i = 0; i < `PCM_NUM_IO; i++) begin
                o_io_out[i] <= i_cfg_mc[i].out_pol;
            end
        end else if (!pwrdn_act) begin
            o_io_out <= mc_out;
        end
    end

    // Output enables, low while driving; power-down pins never drive
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_oe_n <= {`PCM_NUM_IO{`PCM_OE_N_RST}};
        end else if (!pwrdn_act) begin
            o_io_oe_n <= ~oe_want | pwrdn_mask;
        end
        // Held as is in power-down, released pins stay released
    end

    // Slew select per pin, slow out of reset
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_io_fast <= {`PCM_NUM_IO{`PCM_SLEW_RST}};
        end else begin
            o_io_fast <= slew_cfg;
        end
    end

    // ****************************************
    // Standby and signature
    // ****************************************

    // Standby when enabled and either power-down is in force or the bus shows no change
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_standby <= 1'b0;
        end else begin
            o_standby <= i_cfg_standby_en && (pwrdn_act || (next_bus == bus_q));
        end
    end

    // Signature readable whenever out of reset (reset loads zero), no protection gating
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_user_signature <= '0;
        end else begin
            o_user_signature <= i_cfg_signature;
        end
    end

    // ****************************************
    // Checks
    // ****************************************

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_down_hold;
        $past(pwrdn_act) && !$past(i_rst) |-> $stable(o_io_out) && $stable(o_io_oe_n);
    endproperty
    a_down_hold: assert property (p_down_hold) else $error("pins moved while down");

    property p_down_hiz;
        pwrdn_act |=> (o_io_oe_n & $past(o_io_oe_n)) == $past(o_io_oe_n);
    endproperty
    a_down_hiz: assert property (p_down_hiz) else $error("released pin drove");

    property p_down_ignore;
        pwrdn_act |=> $stable(bus_q) && $stable(io_kept);
    endproperty
    a_down_ignore: assert property (p_down_ignore) else $error("input not frozen");

    property p_down_pin;
        i_cfg_pwrdn_en && !$past(i_rst) |-> o_io_oe_n[`PCM_POWER_DOWN_PIN_A_IDX]
            && !bus_q[`PCM_BUS_IO_LSB + `PCM_POWER_DOWN_PIN_B_IDX];
    endproperty
    a_down_pin: assert property (p_down_pin) else $error("down pin used as logic");

    property p_down_pinb;
        i_cfg_pwrdn_en && !$past(i_rst) |-> o_io_oe_n[`PCM_POWER_DOWN_PIN_B_IDX]
            && !bus_q[`PCM_BUS_IO_LSB + `PCM_POWER_DOWN_PIN_A_IDX];
    endproperty
    a_down_pinb: assert property (p_down_pinb) else $error("second down pin used");

    property p_por;
        $past(i_rst) |-> (&o_io_oe_n) && (o_io_fast == '0) && !o_standby
            && (o_user_signature == '0);
    endproperty
    a_por: assert property (p_por) else $error("outputs not at power-up state");

    property p_stby_down;
        i_cfg_standby_en && pwrdn_act |=> o_standby;
    endproperty
    a_stby_down: assert property (p_stby_down) else $error("standby missed");

    property p_slew;
        !$past(i_rst) |-> o_io_fast == $past(slew_cfg);
    endproperty
    a_slew: assert property (p_slew) else $error("slew select wrong");

    property p_sig;
        !$past(i_rst) |-> o_user_signature == $past(i_cfg_signature);
    endproperty
    a_sig: assert property (p_sig) else $error("signature not shown");

    property p_standby;
        o_standby |-> $past(i_cfg_standby_en);
    endproperty
    a_standby: assert property (p_standby) else $error("standby while disabled");
endmodule // pcm_macrocell_ctrl

// *** src/pcm_pkg.sv ***
// Types shared by the macrocell fabric modules
`include "pcm_defines.svh"
package pcm_pkg;
    // ****************************************
    // Selection encodings
    // ****************************************
    // Flip-flop clock source
    typedef enum logic [1:0] {
        PCM_CLK_GLOB0 = 2'h0,
        PCM_CLK_GLOB1 = 2'h1,
        PCM_CLK_GLOB2 = 2'h2,
        PCM_CLK_PT = 2'h3
    } pcm_clk_src_t;
    // Asynchronous clear source
    typedef enum logic [1:0] {
        PCM_CLR_OFF = 2'h0,
        PCM_CLR_GLOBAL = 2'h1,
        PCM_CLR_TERM = 2'h2,
        PCM_CLR_BOTH = 2'h3
    } pcm_clr_src_t;
    // Output enable source
    typedef enum logic [2:0] {
        PCM_OE_INPUT = 3'h0,
        PCM_OE_OUTPUT = 3'h1,
        PCM_OE_PIN0 = 3'h2,
        PCM_OE_PIN0_N = 3'h3,
        PCM_OE_PIN1 = 3'h4,
        PCM_OE_PIN1_N = 3'h5,
        PCM_OE_IOPIN = 3'h6,
        PCM_OE_MCELL = 3'h7
    } pcm_oe_src_t;
    // ****************************************
    // Configuration carriers
    // ****************************************
    // Static options of one macrocell
    typedef struct packed {
        logic [`PCM_NUM_PT-1:0][`PCM_BLK_IN-1:0] pt_true;
        logic [`PCM_NUM_PT-1:0][`PCM_BLK_IN-1:0] pt_comp;
        logic [`PCM_NUM_PT-1:0] sum_pt_en;
        logic [`PCM_REGION-1:0] fold_en;
        logic [2:0] fold_src;
        logic casc_en;
        pcm_clk_src_t clk_src;
        logic clk_en_on;
        pcm_clr_src_t async_reset_select;
        logic async_preset_select;
        logic out_reg;
        logic fb_reg;
        logic out_pol;
        pcm_oe_src_t output_enable_mux;
        logic [4:0] oe_idx;
        logic slew_fast;
        logic low_power;
    } pcm_mc_cfg_t;
    // Switch matrix of one logic block: bus index per block input
    typedef struct packed {
        logic [`PCM_BLK_IN-1:0][6:0] sel;
    } pcm_blk_cfg_t;
endpackage
